/* File: core/usb_mon_regs.svh */
`ifndef USB_MON_REGS_SVH
`define USB_MON_REGS_SVH

// register byte offsets
`define REG_CTRL_OFFSET     8'h00
`define REG_STATUS_OFFSET   8'h04
`define REG_MASK_OFFSET     8'h08

// usb_clock_reset_control field positions
`define GENERAL_FLAG_BIT    26
`define RESUME_FLAG_BIT     25
`define ACTIVITY_FLAG_BIT   24
`define EVENT_LSB           24
`define EVENT_MSB           26
`define RESERVED_ONE_BIT    15
`define ID_OVR_EN_BIT       9
`define ID_OVR_VAL_BIT      8
`define PHY_ID_MON_EN_BIT   7
`define VBUS_MON_EN_BIT     6
`define A_SESS_MON_EN_BIT   5
`define B_SESS_MON_EN_BIT   4
`define SESS_END_MON_EN_BIT 3
`define GENERAL_IE_BIT      2
`define RESUME_IE_BIT       1
`define ACTIVITY_IE_BIT     0

// byte lane holding the event flags
`define EVENT_LANE          3

// byte lanes holding the control fields
`define CTRL_LOW_LANE       0
`define ID_OVR_LANE         1

// reset values
`define EVENT_FLAGS_RESET   3'h1
`define CTRL_LOW_RESET      8'h00
`define ID_OVR_RESET        2'h0
`define MASK_RESET          3'h0
`define ID_IDLE_LEVEL       1'h1

// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: core/usb_mon_pkg.sv */
package usb_mon_pkg;

  // raw levels from the transceiver
  typedef struct packed {
    logic id;
    logic vbus_valid;
    logic a_sess_valid;
    logic b_sess_valid;
    logic sess_end;
  } phy_sense_t;

  // monitor enables driven to the transceiver
  typedef struct packed {
    logic id_mon;
    logic vbus_valid_mon;
    logic a_sess_mon;
    logic b_sess_mon;
    logic sess_end_mon;
  } mon_enable_t;

  // monitored otg levels seen by the controller
  typedef struct packed {
    logic otg_id;
    logic vbus_valid;
    logic a_sess_valid;
    logic b_sess_valid;
    logic sess_end;
  } otg_status_t;

  // event order matches flag bits 26..24
  typedef struct packed {
    logic general;
    logic resume;
    logic activity;
  } usb_events_t;

endpackage

/* File: core/sticky_flags.sv */
`timescale 1ns/100ps
module sticky_flags import usb_mon_pkg::*; #(
  parameter int                W         = 3,
  parameter logic [W-1:0]      RESET_VAL = '0
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // set and clear strobes
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flag state
  output logic [W-1:0]      flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } flag_state_t;

  flag_state_t s;
  flag_state_t next_s;

  // a set in the clearing cycle is kept
  always_comb begin
    next_s = s;
    next_s.flags = (s.flags & ~clr) | set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s.flags <= RESET_VAL;
    end else begin
      s <= next_s;
    end
  end

  assign flags = s.flags;

endmodule

/* File: core/usb_phy_status.sv */
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "usb_mon_regs.svh"
module usb_phy_status import usb_mon_pkg::*; #(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite write address
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  // axi4-lite write data
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  // axi4-lite write response
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // axi4-lite read address
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  // axi4-lite read data
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // usb bus events
  input  wire logic          bus_event,
  input  wire logic          bus_activity,
  input  wire logic          resume_detect,
  input  wire logic          bus_suspended,
  // transceiver side
  input  wire phy_sense_t    phy_sense,
  output mon_enable_t        mon_enable,
  output otg_status_t        otg_status,
  // interrupt
  output logic               irq
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          aw_hold;
    logic          w_hold;
    logic [AW-1:0] waddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic [7:0]    ctrl_low;
    logic [1:0]    id_ovr;
    logic [2:0]    mask;
    mon_enable_t   mon;
    otg_status_t   otg;
    logic          irq;
  } state_t;

  state_t      s;
  state_t      next_s;
  usb_events_t flags;
  usb_events_t set_ev;
  usb_events_t clr_ev;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] mask_word;
  logic [2:0]  ie;
  logic        commit;
  logic        ovr_en;
  logic        ovr_val;
  logic        lane_ctrl_low;
  logic        lane_id_ovr;
  logic        lane_event;
  logic        wr_ctrl;
  logic        wr_status;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;

  ////////////////////////////////////////////////////////////////////////////
  // event capture

  // inputs are levels; a long pulse keeps setting, which is harmless
  always_comb begin
    set_ev.general = bus_event;
    set_ev.resume = resume_detect & bus_suspended;
    set_ev.activity = bus_activity;
  end

  sticky_flags #(
    .W         (`EVENT_MSB - `EVENT_LSB + 1),
    .RESET_VAL (`EVENT_FLAGS_RESET)
  ) u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (set_ev),
    .clr     (clr_ev),
    .flags   (flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register images

  // enables gate the irq; the general enable also gates the general flag read-back in ctrl_word, not in status_word
  assign ie = {s.ctrl_low[`GENERAL_IE_BIT], s.ctrl_low[`RESUME_IE_BIT],
               s.ctrl_low[`ACTIVITY_IE_BIT]};
  assign ovr_en = s.id_ovr[`ID_OVR_EN_BIT - `ID_OVR_VAL_BIT];
  assign ovr_val = s.id_ovr[0];

  always_comb begin
    ctrl_word = '0;
    ctrl_word[`RESERVED_ONE_BIT] = 1'b1;
    ctrl_word[`GENERAL_FLAG_BIT] = flags.general & ie[2];
    ctrl_word[`RESUME_FLAG_BIT] = flags.resume;
    ctrl_word[`ACTIVITY_FLAG_BIT] = flags.activity;
    ctrl_word[`ID_OVR_EN_BIT] = ovr_en;
    ctrl_word[`ID_OVR_VAL_BIT] = ovr_val;
    ctrl_word[7:0] = s.ctrl_low;
    status_word = '0;
    status_word[`EVENT_MSB:`EVENT_LSB] = flags;
    mask_word = '0;
    mask_word[`EVENT_MSB:`EVENT_LSB] = s.mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write-side flag clears

  // response waits for both halves so a write always lands whole
  assign commit = s.aw_hold & s.w_hold;

  // only strobed lanes change their fields
  assign lane_ctrl_low = s.wstrb[`CTRL_LOW_LANE];
  assign lane_id_ovr = s.wstrb[`ID_OVR_LANE];
  assign lane_event = s.wstrb[`EVENT_LANE];
  assign wr_ctrl = commit && (s.waddr == `REG_CTRL_OFFSET);
  assign wr_status = commit && (s.waddr == `REG_STATUS_OFFSET);

  always_comb begin
    clr_ev = '0;
    if (lane_event) begin
      if (wr_status) begin
        // write one to clear
        clr_ev = s.wdata[`EVENT_MSB:`EVENT_LSB];
      end else if (wr_ctrl) begin
        clr_ev.activity = ~s.wdata[`ACTIVITY_FLAG_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  // word latched at the address handshake, so rdata holds while rready waits
  always_comb begin
    rd_word = '0;
    rd_resp = `RESP_OKAY;
    case (araddr)
      `REG_CTRL_OFFSET: begin
        rd_word = ctrl_word;
      end
      `REG_STATUS_OFFSET: begin
        rd_word = status_word;
      end
      `REG_MASK_OFFSET: begin
        rd_word = mask_word;
      end
      default: begin
        rd_resp = `RESP_SLVERR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;

    // write address and data taken in either order
    if (awvalid && s.awready) begin
      next_s.aw_hold = 1'b1;
      next_s.waddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_hold = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end

    // held word applied one edge after the later handshake
    if (commit) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RESP_OKAY;
      case (s.waddr)
        `REG_CTRL_OFFSET: begin
          if (lane_id_ovr) begin
            next_s.id_ovr = s.wdata[`ID_OVR_EN_BIT:`ID_OVR_VAL_BIT];
          end
          if (lane_ctrl_low) begin
            next_s.ctrl_low = s.wdata[7:0];
          end
        end
        `REG_STATUS_OFFSET: begin
          next_s.bresp = `RESP_OKAY;
        end
        `REG_MASK_OFFSET: begin
          if (lane_event) begin
            next_s.mask = s.wdata[`EVENT_MSB:`EVENT_LSB];
          end
        end
        default: begin
          next_s.bresp = `RESP_SLVERR;
        end
      endcase
    end else if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    // one write in flight; ready again once response is gone
    next_s.awready = ~next_s.aw_hold & ~next_s.bvalid;
    next_s.wready = ~next_s.w_hold & ~next_s.bvalid;

    // read channel
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = rd_resp;
      next_s.rdata = rd_word;
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = ~next_s.rvalid;

    // monitor enables follow the control bits
    // id monitoring enable
    next_s.mon.id_mon = s.ctrl_low[`PHY_ID_MON_EN_BIT];
    next_s.mon.vbus_valid_mon = s.ctrl_low[`VBUS_MON_EN_BIT];
    next_s.mon.a_sess_mon = s.ctrl_low[`A_SESS_MON_EN_BIT];
    next_s.mon.b_sess_mon = s.ctrl_low[`B_SESS_MON_EN_BIT];
    next_s.mon.sess_end_mon = s.ctrl_low[`SESS_END_MON_EN_BIT];

    if (ovr_en) begin
      next_s.otg.otg_id = ovr_val;
    end else if (s.ctrl_low[`PHY_ID_MON_EN_BIT]) begin
      next_s.otg.otg_id = phy_sense.id;
    end else begin
      // unmonitored id parks at the b-device level
      next_s.otg.otg_id = `ID_IDLE_LEVEL;
    end
    // levels pass only while their monitor is on
    // gate vbus valid
    next_s.otg.vbus_valid = phy_sense.vbus_valid & s.ctrl_low[`VBUS_MON_EN_BIT];
    next_s.otg.a_sess_valid = phy_sense.a_sess_valid & s.ctrl_low[`A_SESS_MON_EN_BIT];
    next_s.otg.b_sess_valid = phy_sense.b_sess_valid & s.ctrl_low[`B_SESS_MON_EN_BIT];
    next_s.otg.sess_end = phy_sense.sess_end & s.ctrl_low[`SESS_END_MON_EN_BIT];

    next_s.irq = |(flags & s.mask & ie);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // readies low in reset; they rise one edge after release
      s.awready <= 1'b0;
      s.wready <= 1'b0;
      s.aw_hold <= 1'b0;
      s.w_hold <= 1'b0;
      s.waddr <= '0;
      s.wdata <= '0;
      s.wstrb <= '0;
      s.bvalid <= 1'b0;
      s.bresp <= `RESP_OKAY;
      s.arready <= 1'b0;
      s.rvalid <= 1'b0;
      s.rresp <= `RESP_OKAY;
      s.rdata <= '0;
      s.ctrl_low <= `CTRL_LOW_RESET;
      s.id_ovr <= `ID_OVR_RESET;
      s.mask <= `MASK_RESET;
      s.mon <= '0;
      s.otg <= '0;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  // no gate between flop and pin, so output timing never depends on inputs

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign mon_enable = s.mon;
  assign otg_status = s.otg;
  assign irq = s.irq;

endmodule

/* File: dv/usb_phy_model.sv */
`timescale 1ns/100ps
module usb_phy_model import usb_mon_pkg::*; (
  // clock
  input  wire logic       aclk,
  // commanded line levels
  input  wire phy_sense_t want,
  // sensed levels toward the block
  output phy_sense_t      phy_sense
);
  // comparators settle one cycle after the bus moves
  always_ff @(posedge aclk) begin
    phy_sense <= want;
  end
endmodule

/* File: dv/usb_phy_status_assertions.sv */
`timescale 1ns/100ps
module usb_phy_status_assertions import usb_mon_pkg::*; (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // transceiver side
  input wire phy_sense_t  phy_sense,
  input wire mon_enable_t mon_enable,
  input wire otg_status_t otg_status,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  property p_vbus_gate;
    !mon_enable.vbus_valid_mon && !$past(mon_enable.vbus_valid_mon) |-> !otg_status.vbus_valid;
  endproperty
  a_vbus_gate: assert property (p_vbus_gate) else $error("vbus valid while unmonitored");
  property p_vbus_cause;
    otg_status.vbus_valid |-> $past(phy_sense.vbus_valid);
  endproperty
  a_vbus_cause: assert property (p_vbus_cause) else $error("vbus valid without phy level");
  property p_a_gate;
    !mon_enable.a_sess_mon && !$past(mon_enable.a_sess_mon) |-> !otg_status.a_sess_valid;
  endproperty
  a_a_gate: assert property (p_a_gate) else $error("a session valid while unmonitored");
  property p_b_gate;
    !mon_enable.b_sess_mon && !$past(mon_enable.b_sess_mon) |-> !otg_status.b_sess_valid;
  endproperty
  a_b_gate: assert property (p_b_gate) else $error("b session valid while unmonitored");
  property p_rsvd;
    rvalid |-> rdata[31:27] == 5'h00 && rdata[23:16] == 8'h00 && rdata[14:10] == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("unimplemented bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rlat;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_wlat;
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write answer off");

  c_irq: cover property ($rose(irq));
  c_slverr: cover property (bvalid && bresp == 2'h2);
  c_vbus: cover property (otg_status.vbus_valid);
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
`include "usb_mon_regs.svh"
module tb_top import usb_mon_pkg::*;;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, resp;
  logic        bus_event = 1'b0, bus_activity = 1'b0;
  logic        resume_detect = 1'b0, bus_suspended = 1'b0;
  phy_sense_t  want = '0, phy_sense;
  mon_enable_t mon_enable;
  otg_status_t otg_status;
  logic [9:0]  c;
  int          mismatches = 0, checks_done = 0, i;

  always #20 aclk = ~aclk;

  usb_phy_status usb_phy_status_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .bus_event, .bus_activity, .resume_detect, .bus_suspended,
    .phy_sense, .mon_enable, .otg_status, .irq);
  usb_phy_model usb_phy_model_inst (.aclk, .want, .phy_sense);

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] rs);
    int n;
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 40) begin mismatches++; report_and_stop(); end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    araddr <= a; arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    d = rdata; rs = rresp;
    rready <= 1'b0;
    if (n == 40) begin mismatches++; report_and_stop(); end
  endtask

  // one-cycle event, then let flag and irq land
  task automatic pulse(input logic [2:0] e);
    {bus_event, resume_detect, bus_activity} <= e;
    @(posedge aclk);
    {bus_event, resume_detect, bus_activity} <= 3'h0;
    repeat (2) @(posedge aclk);
  endtask

  function automatic otg_status_t exp_otg(logic [9:0] k, phy_sense_t p);
    otg_status_t o;
    o.otg_id = k[9] ? k[8] : (k[7] ? p.id : 1'b1);
    o.vbus_valid = p.vbus_valid & k[6];
    o.a_sess_valid = p.a_sess_valid & k[5];
    o.b_sess_valid = p.b_sess_valid & k[4];
    o.sess_end = p.sess_end & k[3];
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i = $urandom(85);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`REG_CTRL_OFFSET, r, resp);
    chk(r, 32'h0100_8000);
    chk({27'h0, otg_status}, 32'h10);
    rd(8'h0C, r, resp);
    chk({r[31:2], resp}, {30'h0, `RESP_SLVERR});
    wr(8'h0C, 32'hFFFF_FFFF, 4'hF, resp);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    // sleep entry: drop stale activity first
    wr(`REG_CTRL_OFFSET, 32'h0, 4'h8, resp);
    rd(`REG_STATUS_OFFSET, r, resp);
    chk(r, 32'h0);
    pulse(3'h1);
    pulse(3'h2);
    rd(`REG_STATUS_OFFSET, r, resp);
    chk(r, 32'h0100_0000);
    bus_suspended <= 1'b1;
    pulse(3'h2);
    pulse(3'h4);
    rd(`REG_STATUS_OFFSET, r, resp);
    chk(r, 32'h0700_0000);
    rd(`REG_CTRL_OFFSET, r, resp);
    chk({31'h0, r[26]}, 32'h0);
    wr(`REG_MASK_OFFSET, 32'h0400_0000, 4'hF, resp);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(`REG_CTRL_OFFSET, 32'h4, 4'h1, resp);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(`REG_CTRL_OFFSET, r, resp);
    chk({31'h0, r[26]}, 32'h1);
    wr(`REG_STATUS_OFFSET, 32'h0400_0000, 4'h8, resp);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    pulse(3'h4);
    chk({31'h0, irq}, 32'h1);
    wr(`REG_MASK_OFFSET, 32'h0, 4'hF, resp);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    bus_suspended <= 1'b0;
    // override corners first, then random settings
    for (i = 0; i < 16; i++) begin
      c = (i == 0) ? 10'h3FF : (i == 1) ? 10'h200 : 10'($urandom());
      want <= phy_sense_t'(5'($urandom()));
      wr(`REG_CTRL_OFFSET, {22'h0, c}, 4'h3, resp);
      repeat (3) @(posedge aclk);
      chk({27'h0, otg_status}, {27'h0, exp_otg(c, want)});
      chk({27'h0, mon_enable}, {27'h0, c[7:3]});
      rd(`REG_CTRL_OFFSET, r, resp);
      chk(r & 32'hF8FF_FFFF, {16'h0, 1'b1, 5'h0, c});
    end
    report_and_stop();
  end
endmodule

bind usb_phy_status usb_phy_status_assertions chk_inst (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .phy_sense, .mon_enable, .otg_status, .irq);
